// File: shared/chop_pkg.sv
// What this block does
// RQ1 - Turn output on; comparator trip ends ON
// RQ2 - Fixed OFF-time after trip, then restart
// RQ3 - Ignore comparator during blanking after turn-on
// RQ4 - ON period never shorter than blanking
// RQ5 - OFF-time from oscillator, three levels
// RQ6 - Synchronous rectifier MOSFET on during OFF
// RQ7 - Dead time 0.5 us between MOSFET switches
// RQ8 - Load short above 0.45 V disables outputs
// RQ9 - Positive sense during OFF flags coil-open
// RQ10 - Three consecutive coil-open periods qualify protection
// RQ11 - Breakdown time must exceed delay before shutdown
// RQ12 - Unqualified breakdown keeps normal chopping running
// RQ13 - Microstep updates trip target each step
// RQ14 - Trip targets follow sine-shaped ratio sequence
// RQ15 - Stay disabled until supply cycled or standby
// RQ16 - Coil-open detection only while chopping active
// RQ17 - Two phase controllers; any fault stops all
// RQ18 - Per-phase counters cleared on reset, release
//
// Purpose: constants and types for the two-phase chopping controller
// Assumes: 20 MHz clock
// Notes:   sense comparisons are done by analog comparators outside
`default_nettype none
package chop_pkg;
  localparam int CLK_MHZ        = 20;
  localparam int BLANK_STD_NS   = 1500;
  localparam int BLANK_LONG_NS  = 3000;
  localparam int DEAD_NS        = 500;
  localparam int OFF_SHORT_NS   = 4000;
  localparam int OFF_MID_NS     = 8000;
  localparam int OFF_LONG_NS    = 12000;
  localparam int OPEN_DELAY_NS  = 20000;
  localparam int BLANK_STD_CYC  = (BLANK_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_LONG_CYC = (BLANK_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_CYC       = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_SHORT_CYC  = (OFF_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_MID_CYC    = (OFF_MID_NS * CLK_MHZ + 999) / 1000;
  localparam int OFF_LONG_CYC   = (OFF_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int OPEN_DELAY_CYC = (OPEN_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int OPEN_COUNT     = 3;
  localparam int TW             = 10;
  localparam int NSTEP          = 16;
  // Ratio thresholds selecting the OFF-time level
  localparam logic [7:0] RATIO_HI  = 8'hC0;
  localparam logic [7:0] RATIO_MID = 8'h60;

  typedef enum logic [3:0] {
    ST_DEAD_ON  = 4'h1,
    ST_ON       = 4'h2,
    ST_DEAD_OFF = 4'h4,
    ST_OFF      = 4'h8
  } chop_e;

  typedef struct packed {
    chop_e         st;
    logic [TW-1:0] tmr;
    logic [1:0]    open_cnt;
    logic          open_seen;
    logic [TW-1:0] brk_tmr;
  } phase_s;

  typedef struct packed {
    logic main_fet;
    logic rect_fet;
  } gate_s;

  typedef struct packed {
    phase_s [1:0]      ph;
    logic              fault;
    logic [3:0]        step_idx;
    logic [1:0][7:0]   target;
  } state_s;
endpackage
`default_nettype wire

// File: core/stepper_chop.sv
// Purpose: two-phase fixed OFF-time current chopper with fault guard
// Assumes: comparator inputs synchronous to clk
// Notes:   one module holds all state in one packed struct
`timescale 1ns/1ps
`default_nettype none
module stepper_chop
  import chop_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       long_blank,
  input  wire logic       microstep,
  input  wire logic       step_pulse,
  input  wire logic       chop_active,
  input  wire logic       step_mode_sel_a,
  input  wire logic       step_mode_sel_b,
  input  wire logic       step_mode_sel_c,
  input  wire logic [1:0] trip_cmp,
  input  wire logic [1:0] short_cmp,
  input  wire logic [1:0] sense_positive,
  input  wire logic [1:0] breakdown,
  input  wire logic [7:0] ratio_a,
  input  wire logic [7:0] ratio_b,
  output gate_s     [1:0] gate,
  output logic      [7:0] trip_threshold_voltage_a,
  output logic      [7:0] trip_threshold_voltage_b,
  output logic            fault_shutdown
);
  // ----------------------------------------------------------------
  // Sine table
  // ----------------------------------------------------------------
  // Half-wave table; the peak saturates at full scale instead of wrapping
  function automatic logic [7:0] sine_ratio(input logic [3:0] i);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      4'h0:    r = 8'h00;
      4'h1:    r = 8'h32;
      4'h2:    r = 8'h62;
      4'h3:    r = 8'h8E;
      4'h4:    r = 8'hB4;
      4'h5:    r = 8'hD4;
      4'h6:    r = 8'hEC;
      4'h7:    r = 8'hFA;
      4'h8:    r = 8'hFF;
      4'h9:    r = 8'hFA;
      4'hA:    r = 8'hEC;
      4'hB:    r = 8'hD4;
      4'hC:    r = 8'hB4;
      4'hD:    r = 8'h8E;
      4'hE:    r = 8'h62;
      4'hF:    r = 8'h32;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic [TW-1:0] off_len(input logic [7:0] r);
    if (r >= RATIO_HI) return TW'(OFF_LONG_CYC);
    else if (r >= RATIO_MID) return TW'(OFF_MID_CYC);
    else return TW'(OFF_SHORT_CYC);
  endfunction

  // Gates drop with the fault bit itself, so a shutdown takes effect
  // without waiting for either phase to leave its state
  function automatic logic gate_drive(input phase_s ph, input chop_e want, input logic flt);
    return !flt && ph.st == want;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_s          s;
  state_s          next_s;
  logic            release_req;
  logic [7:0]      ratio [1:0];
  logic [TW-1:0]   blank_len;
  logic [1:0]      open_trip;

  assign release_req = step_mode_sel_a & step_mode_sel_b & step_mode_sel_c;
  assign ratio[0]    = microstep ? s.target[0] : ratio_a;
  assign ratio[1]    = microstep ? s.target[1] : ratio_b;
  assign blank_len   = long_blank ? TW'(BLANK_LONG_CYC) : TW'(BLANK_STD_CYC); // [RQ3]

  // Coil-open protection needs both the count and the accumulated breakdown time
  generate
    for (genvar g = 0; g < 2; g++) begin : g_open
      assign open_trip[g] = s.ph[g].open_cnt == 2'(OPEN_COUNT)
                            && s.ph[g].brk_tmr > TW'(OPEN_DELAY_CYC);          // [RQ10] [RQ11]
    end
  endgenerate

  always_comb begin
    next_s = s;
    // --------------------------------------------------------------
    // Microstep trip targets
    // --------------------------------------------------------------
    if (microstep && step_pulse) begin
      next_s.step_idx  = s.step_idx + 4'h1;                                  // [RQ13]
      next_s.target[0] = sine_ratio(s.step_idx + 4'h1);                      // [RQ14]
      next_s.target[1] = sine_ratio(s.step_idx + 4'h5);                      // [RQ14]
    end

    // --------------------------------------------------------------
    // Per-phase chopper
    // --------------------------------------------------------------
    // The phases run free of each other; only the fault bit is shared
    for (int p = 0; p < 2; p++) begin
      case (s.ph[p].st)
        ST_DEAD_ON: begin
          if (s.ph[p].tmr == TW'(DEAD_CYC - 1)) begin                        // [RQ7]
            next_s.ph[p].st  = ST_ON;                                        // [RQ1]
            next_s.ph[p].tmr = '0;
          end else begin
            next_s.ph[p].tmr = s.ph[p].tmr + TW'(1);
          end
        end
        ST_ON: begin
          // The comparator is looked at only once the blank count is spent
          if (s.ph[p].tmr < blank_len) begin
            next_s.ph[p].tmr = s.ph[p].tmr + TW'(1);                         // [RQ3] [RQ4]
          end else if (trip_cmp[p]) begin
            next_s.ph[p].st  = ST_DEAD_OFF;                                  // [RQ1]
            next_s.ph[p].tmr = '0;
          end
        end
        ST_DEAD_OFF: begin
          if (s.ph[p].tmr == TW'(DEAD_CYC - 1)) begin                        // [RQ7]
            next_s.ph[p].st        = ST_OFF;
            next_s.ph[p].tmr       = '0;
            next_s.ph[p].open_seen = 1'b0;
          end else begin
            next_s.ph[p].tmr = s.ph[p].tmr + TW'(1);
          end
        end
        ST_OFF: begin
          if (chop_active && sense_positive[p]) begin
            next_s.ph[p].open_seen = 1'b1;                                   // [RQ9] [RQ16]
          end
          // Saturates; a wrapped timer would hide a long avalanche
          if (chop_active && breakdown[p] && s.ph[p].brk_tmr != '1) begin
            next_s.ph[p].brk_tmr = s.ph[p].brk_tmr + TW'(1);                 // [RQ11]
          end
          if (s.ph[p].tmr >= off_len(ratio[p]) - TW'(1)) begin               // [RQ2] [RQ5]
            next_s.ph[p].st  = ST_DEAD_ON;
            next_s.ph[p].tmr = '0;
            if (next_s.ph[p].open_seen) begin
              if (s.ph[p].open_cnt != 2'(OPEN_COUNT)) begin
                next_s.ph[p].open_cnt = s.ph[p].open_cnt + 2'h1;             // [RQ10]
              end
            end else begin
              next_s.ph[p].open_cnt = '0;                                    // [RQ10] [RQ12]
              next_s.ph[p].brk_tmr  = '0;
            end
          end else begin
            next_s.ph[p].tmr = s.ph[p].tmr + TW'(1);
          end
        end
        default: begin
          next_s.ph[p].st  = ST_DEAD_ON;
          next_s.ph[p].tmr = '0;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Fault guard
    // --------------------------------------------------------------
    if (|open_trip) begin
      next_s.fault = 1'b1;                                                   // [RQ11] [RQ17]
    end
    // Release also clears the qualification, so a stale count cannot re-trip
    if (s.fault && release_req) begin
      next_s.fault = 1'b0;                                                   // [RQ15]
      for (int p = 0; p < 2; p++) begin
        next_s.ph[p].open_cnt  = '0;                                         // [RQ18]
        next_s.ph[p].brk_tmr   = '0;
        next_s.ph[p].open_seen = 1'b0;
        next_s.ph[p].st        = ST_DEAD_ON;
        next_s.ph[p].tmr       = '0;
      end
    end
    // A short seen in the release cycle wins, so a live short is never cleared
    if (|short_cmp) begin
      next_s.fault = 1'b1;                                                   // [RQ8] [RQ17]
    end
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int p = 0; p < 2; p++) begin
        s.ph[p].st        <= ST_DEAD_ON;
        s.ph[p].tmr       <= '0;
        s.ph[p].open_cnt  <= '0;                                             // [RQ18]
        s.ph[p].open_seen <= 1'b0;
        s.ph[p].brk_tmr   <= '0;
        s.target[p]       <= 8'h00;
      end
      s.fault    <= 1'b0;
      s.step_idx <= 4'h0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < 2; g++) begin : g_gate
      assign gate[g].main_fet = gate_drive(s.ph[g], ST_ON, s.fault);         // [RQ1] [RQ17]
      assign gate[g].rect_fet = gate_drive(s.ph[g], ST_OFF, s.fault);        // [RQ6]
    end
  endgenerate
  assign trip_threshold_voltage_a = s.target[0];
  assign trip_threshold_voltage_b = s.target[1];
  assign fault_shutdown           = s.fault;
endmodule // stepper_chop
`default_nettype wire

// File: sim/stepper_chop_monitor.sv
// Purpose: concurrent checks on the chopper ports
// Assumes: one clock domain, sync reset
// Notes:   timing checks watch phase A; overlap covers both
`timescale 1ns/1ps
`default_nettype none
module stepper_chop_monitor
  import chop_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        step_mode_sel_a,
  input wire logic        step_mode_sel_b,
  input wire logic        step_mode_sel_c,
  input wire logic  [1:0] trip_cmp,
  input wire logic  [1:0] short_cmp,
  input wire gate_s [1:0] gate,
  input wire logic        fault_shutdown
);
  logic       rel;
  logic [7:0] on_cnt;
  assign rel = step_mode_sel_a & step_mode_sel_b & step_mode_sel_c;
  // Saturates so a stuck gate cannot wrap back under the blank length
  always_ff @(posedge clk) begin
    if (sys_rst || !gate[0].main_fet) on_cnt <= 8'h00;
    else if (on_cnt != 8'hFF) on_cnt <= on_cnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rect_quiet; !gate[0].rect_fet [*8]; endsequence
  sequence s_main_quiet; !gate[0].main_fet [*8]; endsequence
  property p_no_overlap;
    !(gate[0].main_fet && gate[0].rect_fet) && !(gate[1].main_fet && gate[1].rect_fet);
  endproperty
  property p_dead_on; $fell(gate[0].main_fet) |-> s_rect_quiet; endproperty
  property p_dead_off; $fell(gate[0].rect_fet) && !fault_shutdown |-> s_main_quiet; endproperty
  property p_min_on;
    $fell(gate[0].main_fet) && !fault_shutdown |-> on_cnt >= BLANK_STD_CYC;
  endproperty
  property p_trip;
    gate[0].main_fet && trip_cmp[0] && on_cnt >= BLANK_LONG_CYC |-> ##[0:2] !gate[0].main_fet;
  endproperty
  property p_short; (|short_cmp) |=> fault_shutdown; endproperty
  property p_hold; fault_shutdown && !rel |=> fault_shutdown; endproperty
  property p_release; fault_shutdown && rel && !(|short_cmp) |=> !fault_shutdown; endproperty
  property p_all_off; fault_shutdown && $past(fault_shutdown) |-> gate == '0; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both FETs of a phase on");
  a_dead_on: assert property (p_dead_on) else $error("rectifier on too soon");
  a_dead_off: assert property (p_dead_off) else $error("main FET on too soon");
  a_min_on: assert property (p_min_on) else $error("ON shorter than blank");
  a_trip: assert property (p_trip) else $error("trip did not end ON");
  a_short: assert property (p_short) else $error("short not latched");
  a_hold: assert property (p_hold) else $error("fault dropped early");
  a_release: assert property (p_release) else $error("fault not released");
  a_all_off: assert property (p_all_off) else $error("gate on in fault");
endmodule // stepper_chop_monitor
`default_nettype wire

// File: sim/fet_coil_model.sv
// Purpose: power stage and coil model closing the current loop
// Assumes: current moves one step per clock
// Notes:   coil faults are injected by the bench
`timescale 1ns/1ps
`default_nettype none
module fet_coil_model
  import chop_pkg::*;
(
  input  wire logic        clk,
  input  wire gate_s [1:0] gate,
  input  wire logic  [1:0] coil_open,
  input  wire logic  [1:0] load_short,
  input  wire logic  [7:0] limit,
  output logic       [1:0] trip_cmp,
  output logic       [1:0] short_cmp,
  output logic       [1:0] sense_positive,
  output logic       [1:0] breakdown
);
  logic [7:0] cur [1:0] = '{8'h00, 8'h00};
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (gate[p].main_fet) cur[p] <= cur[p] + 8'h01;
      else if (cur[p] != 8'h00) cur[p] <= cur[p] - 8'h01;
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      trip_cmp[p] = cur[p] >= limit;
      // An open coil reverses sense current whenever the main FET is off
      sense_positive[p] = coil_open[p] & ~gate[p].main_fet;
      breakdown[p] = coil_open[p] & ~gate[p].main_fet;
    end
    short_cmp = load_short;
  end
endmodule // fet_coil_model
`default_nettype wire

// File: sim/tb_stepper_pwm_chop_and_fault_guard.sv
// Purpose: self-checking bench for the two-phase chopper
// Assumes: model trips each ON at blank end (limit below 30)
// Notes:   lengths measured on phase A at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_stepper_pwm_chop_and_fault_guard
  import chop_pkg::*;
;
  logic        clk = 1'b0, sys_rst = 1'b1, long_blank = 1'b0, microstep = 1'b0;
  logic        step_pulse = 1'b0, chop_active = 1'b0, fault_shutdown;
  logic [2:0]  sel = 3'h0;
  logic [1:0]  coil_open = 2'h0, load_short = 2'h0, trip_cmp, short_cmp, sense_pos, brk;
  logic [7:0]  ratio_a = 8'h20, ratio_b = 8'h20, limit = 8'h08, rnd = 8'h02, tva, tvb, t0;
  logic [7:0]  band [3] = '{8'h20, 8'h70, 8'hC0};
  logic [15:0] on_len, dead, off;
  logic [7:0]  wav_a [16], wav_b [16];
  gate_s [1:0] gate;
  int          num_errors = 0, n_compared = 0, cyc = 0, n;
  stepper_chop u_dut (.clk(clk), .sys_rst(sys_rst), .long_blank(long_blank),
    .microstep(microstep), .step_pulse(step_pulse), .chop_active(chop_active),
    .step_mode_sel_a(sel[0]), .step_mode_sel_b(sel[1]), .step_mode_sel_c(sel[2]),
    .trip_cmp(trip_cmp), .short_cmp(short_cmp), .sense_positive(sense_pos), .breakdown(brk),
    .ratio_a(ratio_a), .ratio_b(ratio_b), .gate(gate), .trip_threshold_voltage_a(tva),
    .trip_threshold_voltage_b(tvb), .fault_shutdown(fault_shutdown));
  fet_coil_model u_fet (.clk(clk), .gate(gate), .coil_open(coil_open), .load_short(load_short),
    .limit(limit), .trip_cmp(trip_cmp), .short_cmp(short_cmp), .sense_positive(sense_pos),
    .breakdown(brk));
  initial forever #25 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int off_len(input logic [7:0] r);
    return r >= RATIO_HI ? OFF_LONG_CYC : (r >= RATIO_MID ? OFF_MID_CYC : OFF_SHORT_CYC);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Mode 0 main high, 1 rectifier high, 2 rectifier low; the timeout bounds the wait
  task automatic span(input int m, output logic [15:0] k);
    k = 16'h0000;
    while ((m == 0 ? gate[0].main_fet : gate[0].rect_fet ^ (m == 2)) !== 1'b1) @(negedge clk);
    while ((m == 0 ? gate[0].main_fet : gate[0].rect_fet ^ (m == 2)) === 1'b1) begin
      k++;
      @(negedge clk);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      t0 = band[i % 3] | (rnd & 8'h1F);
      long_blank <= i[0];
      ratio_a <= t0;
      ratio_b <= rnd;
      limit <= 8'h05 + (rnd & 8'h0F);
      span(0, on_len);
      span(2, dead);
      span(1, off);
      chk(on_len, 16'((i[0] ? BLANK_LONG_CYC : BLANK_STD_CYC) + 1));
      chk(dead, 16'(DEAD_CYC));
      chk(off, 16'(off_len(t0)));
    end
    @(posedge clk);
    load_short <= 2'b10;
    repeat (3) @(negedge clk);
    chk(16'(fault_shutdown), 16'h1);
    chk(16'(gate), 16'h0);
    @(posedge clk);
    load_short <= 2'b00;
    sel <= 3'h3;
    repeat (40) @(negedge clk);
    chk(16'(fault_shutdown), 16'h1);
    @(posedge clk);
    sel <= 3'h7;
    @(posedge clk);
    sel <= 3'h0;
    @(negedge clk);
    chk(16'(fault_shutdown), 16'h0);
    @(posedge clk);
    coil_open <= 2'b01;
    repeat (1500) @(negedge clk);
    chk(16'(fault_shutdown), 16'h0);
    @(posedge clk);
    chop_active <= 1'b1;
    span(1, off);
    // A clean OFF between open ones must restart the count
    @(posedge clk);
    coil_open <= 2'b00;
    span(1, off);
    @(posedge clk);
    coil_open <= 2'b01;
    span(1, off);
    span(1, off);
    chk(16'(fault_shutdown), 16'h0);
    for (n = 0; n < 2000 && fault_shutdown !== 1'b1; n++) @(negedge clk);
    chk(16'(fault_shutdown), 16'h1);
    @(posedge clk);
    coil_open <= 2'b00;
    sel <= 3'h7;
    @(posedge clk);
    sel <= 3'h0;
    microstep <= 1'b1;
    repeat (3) @(negedge clk);
    t0 = tva;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      step_pulse <= 1'b1;
      @(posedge clk);
      step_pulse <= 1'b0;
      repeat (3) @(negedge clk);
      wav_a[(k + 1) % 16] = tva;
      wav_b[(k + 1) % 16] = tvb;
      if (k == 0) chk(16'(tva != t0), 16'h1);
    end
    chk(16'(tva), 16'(t0));
    // Rising quarter, mirror symmetry, and phase B four steps ahead
    for (int j = 1; j < 8; j++) begin
      chk(16'(wav_a[j] < wav_a[j + 1]), 16'h1);
      chk(16'(wav_a[j]), 16'(wav_a[16 - j]));
    end
    for (int j = 0; j < 16; j++) begin
      chk(16'(wav_b[j]), 16'(wav_a[(j + 4) % 16]));
    end
    tally_and_finish();
  end
endmodule // tb_stepper_pwm_chop_and_fault_guard
bind stepper_chop stepper_chop_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .step_mode_sel_a(step_mode_sel_a), .step_mode_sel_b(step_mode_sel_b),
  .step_mode_sel_c(step_mode_sel_c), .trip_cmp(trip_cmp), .short_cmp(short_cmp),
  .gate(gate), .fault_shutdown(fault_shutdown));
`default_nettype wire
